// ### design/aaf_top.sv
/*
 Converter sequencing, accumulation and result formatting with an
 Avalon-MM register slave. Assumes the analog SAR core converts on
 conv_go and raises conv_ready with conv_code stable until the next go.
*/
// Notes on behaviour
// R1: High-res mode at repeat four sums four 10-bit conversions into one 12-bit result.
// R2: Each of the four conversions rotates the largest DAC elements.
// R3: High-res only when enabled, burst on, repeat count four or more.
// R4: High-res result at repeat four peaks at 4092, the sum of four 10-bit codes.
// R5: Any power of two from four to 64 allowed; sixteen gives a 14-bit sum.
// R6: Set-sampling on: track once before a set, hold through four.
// R7: Set-sampling off: track again before each conversion of a set.
// R8: Software wanting top throughput sets set-sampling and keeps power on.
// R9: Software at low rates clears set-sampling and sets track time.
// R10: Result bytes written at completion, justified by the justify field.
// R11: Single 10-bit code: 000 low bits, 100 top bits, rest zero.
// R12: Repeat above one sums the series, updating result only at end.
// R13: Repeat count selects 4, 8, 16, 32 or 64 summed samples.
// R14: Software keeps right justification whenever repeat exceeds one.
// R15: Justify field can shift the 16-bit sum right by one to three.
// R16: Burst mode powers converter and reference off when not busy, unless converter_power_on is set.
// R17: Buffer low-power bit drives common-mode buffer low-power state.
// R18: Bias and mux low-power fields set core and buffer power.
// R19: Done flag sets only after the full repeat count is summed.
// R20: In burst one start runs repeat-count conversions back to back.
// R21: Right shift truncates and fills upper bits with zero.
// R22: Accumulator cleared at the start of every new series.
module aaf_top
   import aaf_pkg::*;
#(
   parameter int CODE_W = 10,
   parameter int ACC_W  = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   input  wire logic        conv_trigger,
   input  wire logic        conv_ready,
   input  wire logic [9:0]  conv_code,
   output      logic        conv_go,
   output      logic        track_en,
   output      logic [1:0]  ref_level_sel,
   output      logic [1:0]  dem_rotate,
   output      logic        core_power,
   output      logic        ref_power,
   output      logic        buffer_low_power,
   output      logic [2:0]  mux_low_power,
   output      logic [3:0]  core_bias_select,
   output      logic [4:0]  sar_clock_divider
);
   if (CODE_W != 10 || ACC_W != 16) begin : g_chk
      $error("aaf_top supports only a 10-bit code and a 16-bit accumulator");
   end

   aaf_acc_if acc_if ();

   aaf_accum u_accum (
      .clk (clk),
      .rst (rst),
      .acc (acc_if.acc)
   );

   aaf_format u_format (
      .fmt (acc_if.fmt)
   );

   // Configuration
   logic [10:0] accum_cfg_reg;
   logic [6:0]  track_cfg_reg;
   logic [12:0] power_cfg_reg;
   logic        done_flag_reg;
   logic [15:0] result_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;

   wire       burst_enable       = accum_cfg_reg[F_BURST];
   wire       converter_power_on = accum_cfg_reg[F_PWR_ON];
   wire       hires_enable       = accum_cfg_reg[F_HIRES];
   wire [2:0] repeat_count_select = accum_cfg_reg[F_RPT_LSB +: 3];
   wire [2:0] justify_shift_select = accum_cfg_reg[F_JST_LSB +: 3];
   wire [5:0] burst_track_time   = track_cfg_reg[F_TRACK_LSB +: 6];
   wire       set_sample_hold    = track_cfg_reg[F_SSH];

   // Bus decode
   wire       bus_req   = avs_read | avs_write;
   wire       bus_take  = bus_req & ~ack_reg;
   wire       wr_take   = avs_write & ack_reg;
   wire       sel_accum = avs_address == OFS_ACCUM_CFG;
   wire       sel_track = avs_address == OFS_TRACK_CFG;
   wire       sel_power = avs_address == OFS_POWER_CFG;
   wire       sel_stat  = avs_address == OFS_STATUS;
   wire       sel_res   = avs_address == OFS_RESULT;
   wire       sw_start  = wr_take & sel_accum & avs_writedata[F_START];
   wire       flag_clr  = wr_take & sel_stat & avs_writedata[F_DONE];

   assign avs_waitrequest = bus_req & ~ack_reg;

   // Pin synchronisers
   logic       trig_s1_reg, trig_s2_reg, trig_prev_reg;
   logic       rdy_s1_reg, rdy_s2_reg, rdy_prev_reg;
   logic [9:0] code_s1_reg, code_s2_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {trig_s1_reg, trig_s2_reg, trig_prev_reg} <= 3'h0;
         {rdy_s1_reg, rdy_s2_reg, rdy_prev_reg} <= 3'h0;
         code_s1_reg <= 10'h000;
         code_s2_reg <= 10'h000;
      end else begin
         {trig_prev_reg, trig_s2_reg, trig_s1_reg} <= {trig_s2_reg, trig_s1_reg, conv_trigger};
         {rdy_prev_reg, rdy_s2_reg, rdy_s1_reg} <= {rdy_s2_reg, rdy_s1_reg, conv_ready};
         code_s1_reg <= conv_code;
         code_s2_reg <= code_s1_reg;
      end
   end

   wire pin_start  = trig_s2_reg & ~trig_prev_reg;
   wire conv_done  = rdy_s2_reg & ~rdy_prev_reg;

   // SAR clock enable divider
   logic [4:0] div_cnt_reg;
   wire        sar_tick = div_cnt_reg == sar_clock_divider;

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         div_cnt_reg <= 5'h00;
      else
         div_cnt_reg <= sar_tick ? 5'h00 : div_cnt_reg + 5'h01;
   end

   // Sequencer
   aaf_state_t state_reg, state_next;
   logic [6:0] timer_reg, timer_next;
   logic [6:0] cnt_reg, cnt_next;
   logic [6:0] target;

   always_comb begin
      case (repeat_count_select)
         RPT_4:   target = 7'd4;
         RPT_8:   target = 7'd8;
         RPT_16:  target = 7'd16;
         RPT_32:  target = 7'd32;
         RPT_64:  target = 7'd64;
         default: target = 7'd1;
      endcase
   end

   wire hires_active = hires_enable & burst_enable & (target != 7'd1); // R3
   wire busy         = state_reg != ST_IDLE;
   wire can_start    = ~busy & (burst_enable | converter_power_on);
   wire start        = (sw_start | pin_start) & can_start; // R20
   wire last_conv    = cnt_reg + 7'd1 == target;
   wire series_done  = (state_reg == ST_CONV) & conv_done & last_conv;
   wire [6:0] cnt_inc = cnt_reg + 7'd1;
   // Later conversions of a held set skip tracking entirely
   wire skip_track   = hires_active & set_sample_hold & (cnt_inc[1:0] != 2'h0); // R6 R7
   wire [6:0] later_track = {1'b0, burst_track_time};

   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               if (burst_enable & ~converter_power_on) begin
                  state_next = ST_PWRUP;
                  timer_next = PWRUP_SAR;
               end else begin
                  state_next = ST_TRACK;
                  timer_next = TRACK_FIRST_SAR;
               end
            end
         end
         ST_PWRUP: begin
            if (sar_tick) begin
               if (timer_reg == 7'd0) begin
                  state_next = ST_TRACK;
                  timer_next = TRACK_FIRST_SAR;
               end else
                  timer_next = timer_reg - 7'd1;
            end
         end
         ST_TRACK: begin
            if (sar_tick) begin
               if (timer_reg == 7'd0)
                  state_next = ST_CONV;
               else
                  timer_next = timer_reg - 7'd1;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               if (last_conv) begin
                  state_next = ST_IDLE; // R19
                  cnt_next   = 7'd0;
               end else begin
                  cnt_next = cnt_inc;
                  if (!burst_enable)
                     state_next = ST_IDLE;
                  else if (skip_track)
                     state_next = ST_CONV; // R6
                  else begin
                     state_next = ST_TRACK; // R7 R20
                     timer_next = later_track;
                  end
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // A held-set conversion restarts the core straight from CONV
   wire go_next = (state_reg == ST_TRACK & state_next == ST_CONV) |
                  (state_reg == ST_CONV & conv_done & ~last_conv & burst_enable & skip_track);

   assign acc_if.clear   = start & (cnt_reg == 7'd0); // R22
   assign acc_if.add     = (state_reg == ST_CONV) & conv_done; // R12
   assign acc_if.code    = code_s2_reg;
   assign acc_if.justify = justify_shift_select;

   logic       go_reg, track_reg, cpwr_reg;
   logic [1:0] step_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         timer_reg <= 7'd0;
         cnt_reg   <= 7'd0;
         go_reg    <= 1'b0;
         track_reg <= 1'b0;
         cpwr_reg  <= 1'b0;
         step_reg  <= 2'h0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         cnt_reg   <= cnt_next;
         go_reg    <= go_next;
         track_reg <= state_next == ST_TRACK;
         // Burst holds power only while busy unless kept on
         cpwr_reg  <= converter_power_on | (burst_enable & state_next != ST_IDLE); // R16
         step_reg  <= hires_active ? cnt_next[1:0] : 2'h0; // R1 R2
      end
   end

   assign conv_go       = go_reg;
   assign track_en      = track_reg;
   assign ref_level_sel = step_reg; // R1
   assign dem_rotate    = step_reg; // R2
   assign core_power    = cpwr_reg; // R16
   assign ref_power     = cpwr_reg; // R16

   assign buffer_low_power  = power_cfg_reg[F_LPM]; // R17
   assign mux_low_power     = power_cfg_reg[F_MXLP_LSB +: 3]; // R18
   assign core_bias_select  = power_cfg_reg[F_BIAS_LSB +: 4]; // R18
   assign sar_clock_divider = power_cfg_reg[F_DIV_LSB +: 5];

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accum_cfg_reg <= ACCUM_CFG_RST;
         track_cfg_reg <= TRACK_CFG_RST;
         power_cfg_reg <= POWER_CFG_RST;
      end else if (wr_take) begin
         if (sel_accum)
            accum_cfg_reg <= avs_writedata[10:0];
         if (sel_track)
            track_cfg_reg <= avs_writedata[6:0];
         if (sel_power)
            power_cfg_reg <= avs_writedata[12:0];
      end
   end

   // Result is sampled one cycle after the final add lands in the sum
   logic res_load_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         res_load_reg <= 1'b0;
      else
         res_load_reg <= series_done;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_reg    <= 16'h0000;
         done_flag_reg <= 1'b0;
      end else begin
         if (res_load_reg)
            result_reg <= acc_if.formatted; // R10 R12
         // A completion in the clearing cycle wins
         done_flag_reg <= series_done | (done_flag_reg & ~flag_clr); // R19
      end
   end

   wire [31:0] status_word = {29'h0, hires_active, busy, done_flag_reg};
   wire [31:0] rd_mux = sel_accum ? {21'h0, accum_cfg_reg} :
                        sel_track ? {25'h0, track_cfg_reg} :
                        sel_power ? {19'h0, power_cfg_reg} :
                        sel_stat  ? status_word :
                        sel_res   ? {16'h0, result_reg} : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg   <= bus_take;
         rdata_reg <= rd_mux;
      end
   end
   assign avs_readdata = ack_reg ? rdata_reg : 32'h0;

   sequence s_final_add;
      acc_if.add && last_conv;
   endsequence

   sequence s_idle_burst_off;
      burst_enable && !converter_power_on && state_reg == ST_IDLE;
   endsequence

   AST_HIRES_GATE: assert property (@(posedge clk) disable iff (rst) // R3
      step_reg != 2'h0 |-> $past(hires_enable) && $past(burst_enable))
      else $error("reference step moved outside high-res mode");
   AST_HIRES_MAX: assert property (@(posedge clk) disable iff (rst) // R4
      s_final_add ##0 (hires_active && repeat_count_select == RPT_4 && justify_shift_select == 3'h0)
      |=> acc_if.sum <= {4'h0, HIRES_MAX})
      else $error("high-res sum above 4092");
   AST_HOLD_SET: assert property (@(posedge clk) disable iff (rst) // R6
      (state_reg == ST_TRACK) |-> !(hires_active && set_sample_hold && cnt_reg[1:0] != 2'h0))
      else $error("tracking inside a held set");
   AST_RETRACK: assert property (@(posedge clk) disable iff (rst) // R7
      (conv_go && !set_sample_hold && $stable(track_cfg_reg)) |-> $past(state_reg) == ST_TRACK)
      else $error("conversion without tracking");
   AST_RESULT_END: assert property (@(posedge clk) disable iff (rst) // R12
      !$stable(result_reg) |-> $past(res_load_reg))
      else $error("result changed mid series");
   AST_FLAG_COUNT: assert property (@(posedge clk) disable iff (rst) // R19
      $rose(done_flag_reg) |-> $past(cnt_reg) + 7'd1 == $past(target))
      else $error("done flag before repeat count");
   AST_CLEAR: assert property (@(posedge clk) disable iff (rst) // R22
      acc_if.clear && !acc_if.add |=> acc_if.sum == 16'h0000)
      else $error("accumulator not cleared at series start");
   AST_BURST_OFF: assert property (@(posedge clk) disable iff (rst) // R16
      s_idle_burst_off [*2] |-> !core_power && !ref_power)
      else $error("converter powered while idle in burst");
   AST_BURST_RUN: assert property (@(posedge clk) disable iff (rst) // R20
      (state_reg == ST_CONV && conv_done && !last_conv && burst_enable) |=> state_reg != ST_IDLE)
      else $error("burst stopped before repeat count");
   AST_LEFT: assert property (@(posedge clk) disable iff (rst) // R11
      res_load_reg && justify_shift_select == JST_LEFT |=> result_reg[5:0] == 6'h00)
      else $error("left justify low bits not zero");
   AST_SHIFT_ZERO: assert property (@(posedge clk) disable iff (rst) // R21
      justify_shift_select == 3'h3 |-> acc_if.formatted == {3'h0, acc_if.sum[15:3]})
      else $error("right shift not zero filled");
endmodule

// ### design/aaf_pkg.sv
/*
 Shared constants for the converter sequencing and result logic.
 Assumes a 20 MHz clock and 32-bit Avalon-MM words at byte addresses.
*/
package aaf_pkg;
   localparam int          CLK_HZ          = 20_000_000;
   // Register byte offsets
   localparam logic [7:0]  OFS_ACCUM_CFG   = 8'h00;
   localparam logic [7:0]  OFS_TRACK_CFG   = 8'h04;
   localparam logic [7:0]  OFS_POWER_CFG   = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0c;
   localparam logic [7:0]  OFS_RESULT      = 8'h10;
   // accumulator_config_reg fields
   localparam int          F_BURST         = 0;
   localparam int          F_PWR_ON        = 1;
   localparam int          F_HIRES         = 2;
   localparam int          F_RPT_LSB       = 4;
   localparam int          F_JST_LSB       = 8;
   localparam int          F_START         = 16;
   // tracking_config_reg fields
   localparam int          F_TRACK_LSB     = 0;
   localparam int          F_SSH           = 6;
   // power_config_reg fields
   localparam int          F_LPM           = 0;
   localparam int          F_MXLP_LSB      = 1;
   localparam int          F_BIAS_LSB      = 4;
   localparam int          F_DIV_LSB       = 8;
   // Status fields
   localparam int          F_DONE          = 0;
   localparam int          F_BUSY          = 1;
   localparam int          F_HIRES_ACT     = 2;
   // Reset values
   localparam logic [10:0] ACCUM_CFG_RST   = 11'h000;
   localparam logic [6:0]  TRACK_CFG_RST   = 7'h00;
   localparam logic [12:0] POWER_CFG_RST   = 13'h0000;
   // Repeat count encodings and counts
   localparam logic [2:0]  RPT_1           = 3'h0;
   localparam logic [2:0]  RPT_4           = 3'h1;
   localparam logic [2:0]  RPT_8           = 3'h2;
   localparam logic [2:0]  RPT_16          = 3'h3;
   localparam logic [2:0]  RPT_32          = 3'h4;
   localparam logic [2:0]  RPT_64          = 3'h5;
   localparam logic [2:0]  JST_LEFT        = 3'h4;
   localparam int          LEFT_SHIFT      = 6;
   localparam logic [6:0]  TRACK_FIRST_SAR = 7'h04;
   localparam logic [6:0]  PWRUP_SAR       = 7'h10;
   localparam logic [11:0] HIRES_MAX       = 12'hffc;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PWRUP, ST_TRACK, ST_CONV
   } aaf_state_t;
endpackage

// ### design/aaf_acc_if.sv
/*
 Carrier between sequencer, accumulator and formatter.
 Assumes all three parties run on the same clock.
*/
interface aaf_acc_if;
   logic        clear;
   logic        add;
   logic [9:0]  code;
   logic [15:0] sum;
   logic [2:0]  justify;
   logic [15:0] formatted;
   modport seq (output clear, add, code, justify, input sum, formatted);
   modport acc (input clear, add, code, output sum);
   modport fmt (input sum, justify, output formatted);
endinterface

// ### design/aaf_accum.sv
/*
 16-bit unsigned accumulator of converter codes.
 Assumes clear and add come from the sequencer on the same clock.
*/
module aaf_accum
   import aaf_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   aaf_acc_if.acc    acc
);
   logic [15:0] sum_reg;
   wire  [15:0] base = acc.clear ? 16'h0000 : sum_reg; // R22

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         sum_reg <= 16'h0000;
      else if (acc.add)
         sum_reg <= base + {6'h00, acc.code}; // R1 R4 R5 R13
      else if (acc.clear)
         sum_reg <= 16'h0000; // R22
   end
   assign acc.sum = sum_reg;
endmodule

// ### design/aaf_format.sv
/*
 Justification and right-shift of the accumulated sum.
 Assumes the sum and select are stable; output is registered by the user.
*/
module aaf_format
   import aaf_pkg::*;
(
   aaf_acc_if.fmt fmt
);
   // Left justify places the 10-bit field at the top; right shifts drop low bits
   wire [15:0] left_val = {fmt.sum[9:0], 6'h00}; // R11
   wire [15:0] shr_val  = fmt.sum >> fmt.justify[1:0]; // R15 R21

   assign fmt.formatted = (fmt.justify == JST_LEFT) ? left_val : shr_val; // R10
endmodule

// ### verification/aaf_tb_top.sv
/*
 Self-checking bench for aaf_top: register access over Avalon-MM, series runs and result formatting.
 Assumes the bench itself stands in for the analog SAR core, answering each conv_go after a few cycles.
*/
module aaf_tb_top
   import aaf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        conv_trigger;
   logic        conv_ready = 1'b0;
   logic [9:0]  conv_code  = 10'h000;
   logic [9:0]  code_val   = 10'h000;
   logic        conv_go;
   logic        track_en;
   logic [1:0]  ref_level_sel;
   logic [1:0]  dem_rotate;
   logic        core_power;
   logic        ref_power;
   logic        buffer_low_power;
   logic [2:0]  mux_low_power;
   logic [3:0]  core_bias_select;
   logic [4:0]  sar_clock_divider;
   logic [3:0]  ref_mask   = 4'h0;
   logic [3:0]  dem_mask   = 4'h0;
   logic        pwr_ok     = 1'b1;
   logic        trk_q      = 1'b0;
   int          errors     = 0;
   int          samples_checked = 0;
   int          cycles     = 0;
   int          go_cnt     = 0;
   int          trk_cnt    = 0;
   int          rdy_cnt    = 0;

   aaf_top u_aaf_top (
      .clk               (clk),
      .rst               (rst),
      .avs_address       (avs_address),
      .avs_read          (avs_read),
      .avs_write         (avs_write),
      .avs_writedata     (avs_writedata),
      .avs_readdata      (avs_readdata),
      .avs_waitrequest   (avs_waitrequest),
      .conv_trigger      (conv_trigger),
      .conv_ready        (conv_ready),
      .conv_code         (conv_code),
      .conv_go           (conv_go),
      .track_en          (track_en),
      .ref_level_sel     (ref_level_sel),
      .dem_rotate        (dem_rotate),
      .core_power        (core_power),
      .ref_power         (ref_power),
      .buffer_low_power  (buffer_low_power),
      .mux_low_power     (mux_low_power),
      .core_bias_select  (core_bias_select),
      .sar_clock_divider (sar_clock_divider)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Analog core stand-in; the code changes only at conv_go so it is stable across the ready edge
   always @(posedge clk) begin
      cycles <= cycles + 1;
      trk_q <= track_en;
      if (track_en === 1'b1 && trk_q === 1'b0) trk_cnt <= trk_cnt + 1;
      // A taken configuration write opens a fresh run for the per-run observations
      if (avs_write === 1'b1 && avs_waitrequest === 1'b0 && avs_address == OFS_ACCUM_CFG) begin
         ref_mask <= 4'h0;
         dem_mask <= 4'h0;
         pwr_ok <= 1'b1;
      end else if (conv_go === 1'b1) begin
         ref_mask[ref_level_sel] <= 1'b1;
         dem_mask[dem_rotate] <= 1'b1;
         if (core_power !== 1'b1) pwr_ok <= 1'b0;
      end
      if (conv_go === 1'b1) begin
         go_cnt <= go_cnt + 1;
         conv_ready <= 1'b0;
         conv_code <= code_val;
         rdy_cnt <= 6;
      end else if (rdy_cnt > 0) begin
         rdy_cnt <= rdy_cnt - 1;
         if (rdy_cnt == 1) conv_ready <= 1'b1;
      end
      if (cycles == 80000) begin
         errors++;
         summarize();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Waits a full edge first so back-to-back calls never reassign a strobe in one time step
   task automatic av_rw(input logic wr_n_rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr_n_rd;
      avs_read <= ~wr_n_rd;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      av_rw(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      av_rw(1'b0, a, 32'h0000_0000, q);
   endtask

   function automatic logic [31:0] cfg(input logic b, p, h, input logic [2:0] r, j);
      return {21'h000000, j, 1'b0, r, 1'b0, h, p, b};
   endfunction

   task automatic wait_done();
      logic [31:0] s;
      int          k;
      s = 32'h0;
      k = 0;
      while (s[0] !== 1'b1 && k < 3000) begin
         rd(OFS_STATUS, s);
         k++;
      end
      check("done_flag", 32'(s[0]), 32'h1);
      wr(OFS_STATUS, 32'h0000_0001);
   endtask

   task automatic run(input logic [31:0] c, input logic [9:0] code, input logic pin,
                      output logic [15:0] res, output int ngo);
      int          g0;
      logic [31:0] q;
      code_val = code;
      g0 = go_cnt;
      wr(OFS_ACCUM_CFG, c);
      if (pin) begin
         @(posedge clk);
         conv_trigger <= 1'b1;
         repeat (4) @(posedge clk);
         conv_trigger <= 1'b0;
      end else begin
         wr(OFS_ACCUM_CFG, c | 32'h0001_0000);
      end
      wait_done();
      rd(OFS_RESULT, q);
      res = q[15:0];
      ngo = go_cnt - g0;
   endtask

   task automatic summarize();
      if (errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      logic [31:0] q;
      logic [15:0] res;
      int          n;
      int          t0;
      int          sh;
      rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      conv_trigger = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Unmapped write must not land anywhere, so every offset still reads its reset value
      wr(8'h14, 32'hffff_ffff);
      for (int i = 0; i < 6; i++) begin
         rd(8'(i * 4), q);
         check("reset_read", q, 32'h0);
      end
      wr(OFS_POWER_CFG, 32'h0000_1f5b);
      // The write lands at the edge that ends the access; look once it has settled
      @(posedge clk);
      check("buffer_low_power", 32'(buffer_low_power), 32'h1);
      check("mux_low_power", 32'(mux_low_power), 32'h5);
      check("core_bias_select", 32'(core_bias_select), 32'h5);
      check("sar_clock_divider", 32'(sar_clock_divider), 32'h1f);
      wr(OFS_POWER_CFG, 32'h0000_0000);
      wr(OFS_TRACK_CFG, 32'h0000_0002);
      run(cfg(0, 1, 0, RPT_1, 3'h0), 10'h3ff, 1'b0, res, n);
      check("right_justified", 32'(res), 32'h03ff);
      run(cfg(0, 1, 0, RPT_1, JST_LEFT), 10'h201, 1'b1, res, n);
      check("left_justified", 32'(res), 32'h8040);
      run(cfg(1, 1, 0, RPT_1, 3'h3), 10'h3ff, 1'b0, res, n);
      check("truncated_shift", 32'(res), 32'h007f);
      // Non-burst: one start per conversion, no completion before the fourth
      code_val = 10'h123;
      wr(OFS_ACCUM_CFG, cfg(0, 1, 0, RPT_4, 3'h0));
      for (int i = 0; i < 3; i++) begin
         wr(OFS_ACCUM_CFG, cfg(0, 1, 0, RPT_4, 3'h0) | 32'h0001_0000);
         repeat (40) @(posedge clk);
         rd(OFS_STATUS, q);
         check("early_done", 32'(q[0]), 32'h0);
      end
      wr(OFS_ACCUM_CFG, cfg(0, 1, 0, RPT_4, 3'h0) | 32'h0001_0000);
      wait_done();
      rd(OFS_RESULT, q);
      check("nonburst_sum", q, 32'h0000_048c);
      for (int r = 1; r < 6; r++) begin
         sh = (r - 1) % 4;
         run(cfg(1, 1, 0, 3'(r), 3'(sh)), 10'h3ff, 1'b0, res, n);
         check("burst_sum", 32'(res), 32'((1023 << (r + 1)) >> sh));
         check("burst_go_count", 32'(n), 32'(4 << (r - 1)));
      end
      wr(OFS_TRACK_CFG, 32'h0000_007f);
      t0 = trk_cnt;
      run(cfg(1, 1, 1, RPT_4, 3'h0), 10'h3ff, 1'b0, res, n);
      check("hires_max", 32'(res), 32'(HIRES_MAX));
      check("ref_levels", 32'(ref_mask), 32'hf);
      check("dem_steps", 32'(dem_mask), 32'hf);
      check("held_tracks", 32'(trk_cnt - t0), 32'h1);
      wr(OFS_TRACK_CFG, 32'h0000_0002);
      t0 = trk_cnt;
      run(cfg(1, 1, 1, RPT_16, 3'h0), 10'h3ff, 1'b0, res, n);
      check("hires_14bit", 32'(res), 32'h3ff0);
      check("each_tracks", 32'(trk_cnt - t0), 32'h10);
      run(cfg(1, 1, 1, RPT_1, 3'h0), 10'h3ff, 1'b0, res, n);
      check("hires_inactive", 32'(ref_mask), 32'h1);
      run(cfg(1, 0, 0, RPT_4, 3'h0), 10'h010, 1'b0, res, n);
      check("poweroff_sum", 32'(res), 32'h0040);
      check("powered_in_burst", 32'(pwr_ok), 32'h1);
      check("core_power_idle", 32'(core_power), 32'h0);
      check("ref_power_idle", 32'(ref_power), 32'h0);
      summarize();
   end
endmodule
